// File: fifo_flag_select_and_polarity_tb.sv
// Self-checking bench for the flag select and polarity register bank.
// Assumes flag_master_model drives the command port.
`default_nettype none

module fifo_flag_select_and_polarity_tb import flag_polarity_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk, rst, pin_d, rd_valid, pa, pb, pc, pd, pd_oe, cs;
	logic [2:0] fsel;
	logic [7:0] rd_data, v;
	cmd_t cmd;
	fifo_status_t status;
	strobe_t raw, act;
	int miscompares = 0;
	int n_compared = 0;

	flag_polarity_regs #(.ENDPOINTS(4)) dut_u (.sys_clk_i(sys_clk),
		.rst_i(rst), .cmd_i(cmd), .fifo_select_pins_i(fsel),
		.fifo_status_i(status), .strobe_i(raw), .pin_d_i(pin_d),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .status_pin_a_o(pa),
		.status_pin_b_o(pb), .status_pin_c_o(pc), .status_pin_d_o(pd),
		.status_pin_d_oe_o(pd_oe), .chip_select_o(cs),
		.strobe_active_o(act));

	flag_master_model master_u (.sys_clk_i(sys_clk), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid), .cmd_o(cmd));

	////////////////////////////////////////////////////////////////////////
	task automatic check8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic check1(input string what, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic read_check(input logic [7:0] a, input logic [7:0] e);
		master_u.read_byte(a, v);
		check8("register read", e, v);
	endtask

	task automatic check_strobes(input logic [7:0] p);
		strobe_t r;
		for (int i = 0; i < 2; i++) begin
			r = i ? 5'b0_1010 : 5'b1_0101;
			raw = r;
			settle(2);
			r = r ~^ {p[7], p[5], p[4], p[3], p[2]};
			check8("strobes", {3'b000, r}, {3'b000, act});
		end
	endtask

	function automatic logic exp_flag(int pin, logic [3:0] code,
		fifo_status_t s, logic [1:0] aep, logic [7:0] p);
		logic [1:0] ep;
		logic [1:0] kind;
		ep = (code == SEL_FIXED) ? aep : code[1:0];
		kind = code[3:2];
		if (code == SEL_FIXED) begin
			kind = (pin == 0) ? KIND_PROG : (pin == 1) ? KIND_FULL :
				(pin == 2) ? KIND_EMPTY : 2'b00;
		end
		case (kind)
			KIND_PROG: return s.prog[ep];
			KIND_EMPTY: return ~(s.empty[ep] ^ p[1]);
			KIND_FULL: return ~(s.full[ep] ^ p[0]);
			default: return ~p[0];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		read_check(REG_IFACE_CONFIG, 8'hC9);
		read_check(REG_FLAG_SELECT_AB, 8'h00);
		read_check(REG_FLAG_SELECT_CD, 8'h00);
		read_check(REG_PIN_POLARITY, 8'h00);
		read_check(8'h20, 8'h00);
		check1("chip select", 1'b1, cs);
		check1("pin d enable", 1'b0, pd_oe);
		$display("test reset done");
	endtask

	task automatic t_routing();
		logic [7:0] p;
		logic [3:0] pins;
		fifo_status_t s;
		master_u.write_byte(REG_IFACE_CONFIG, 8'hCB);
		settle(2);
		check1("pin d enable", 1'b1, pd_oe);
		check1("chip select", 1'b0, cs);
		for (int k = 0; k < 2; k++) begin
			p = k ? 8'h03 : 8'h00;
			master_u.write_byte(REG_PIN_POLARITY, p);
			for (int pin = 0; pin < 4; pin++) begin
				for (int c = 0; c < 16; c++) begin
					master_u.write_byte(pin < 2 ? REG_FLAG_SELECT_AB :
						REG_FLAG_SELECT_CD, 8'(c << (4 * (pin % 2))));
					for (int j = 0; j < 2; j++) begin
						s = {4'b0110, 4'b1010, 4'b0011};
						s = j ? ~s : s;
						status = s;
						fsel = 3'(pin + c);
						settle(2);
						pins = {pd, pc, pb, pa};
						check1("flag pin", exp_flag(pin, 4'(c), s, fsel[1:0], p),
							pins[pin]);
					end
				end
			end
		end
		master_u.write_byte(REG_IFACE_CONFIG, 8'hC9);
		pin_d = 1'b1;
		settle(2);
		check1("chip select idle", 1'b0, cs);
		$display("test routing done");
	endtask

	task automatic t_polarity();
		master_u.write_byte(REG_PIN_POLARITY, 8'hFF);
		read_check(REG_PIN_POLARITY, 8'hA3);
		check_strobes(8'hA3);
		master_u.write_byte(REG_PIN_POLARITY, 8'h00);
		check_strobes(8'h00);
		$display("test polarity done");
	endtask

	task automatic t_extended();
		master_u.ext_merge(8'h1C, 8'h00);
		read_check(REG_PIN_POLARITY, 8'h1C);
		check_strobes(8'h1C);
		read_check(REG_EXT_POINTER_LOW, 8'h09);
		read_check(REG_EXT_POINTER_HIGH, 8'hE6);
		master_u.ext_write(16'hE608, 8'h00);
		read_check(REG_PIN_POLARITY, 8'h1C);
		// A lone nibble must be dropped by the next address write.
		master_u.pulse({3'b100, REG_PIN_POLARITY, 4'h0});
		master_u.pulse({3'b010, REG_PIN_POLARITY, 4'h0});
		master_u.write_byte(REG_PIN_POLARITY, 8'h81);
		read_check(REG_PIN_POLARITY, 8'h9D);
		master_u.ext_merge(8'h00, 8'h1C);
		read_check(REG_PIN_POLARITY, 8'h81);
		$display("test extended done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// The tests need about 1500 cycles; this limit is more than 25 times that.
	initial begin
		#2_000_000;
		miscompares++;
		results();
	end

	initial begin
		rst = 1'b1;
		pin_d = 1'b0;
		fsel = 3'b000;
		status = '0;
		raw = '0;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_routing();
		t_polarity();
		t_extended();
		results();
	end
endmodule

`default_nettype wire

// File: flag_master_model.sv
// Behavioural external master for the flag select and polarity block.
// Assumes the command port samples single-cycle strobes on sys_clk_i.
`default_nettype none

module flag_master_model
	import flag_polarity_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output var cmd_t cmd_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial cmd_o = '0;

	////////////////////////////////////////////////////////////////////////
	task automatic pulse(input cmd_t c);
		@(posedge sys_clk_i);
		#1;
		cmd_o = c;
		@(posedge sys_clk_i);
		#1;
		// The idle bus shows the inverse, so stale data never passes.
		cmd_o = {3'b000, ~c.addr, ~c.nibble};
	endtask

	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
		pulse({3'b100, a, 4'h0});
		pulse({3'b010, a, d[7:4]});
		pulse({3'b010, a, d[3:0]});
	endtask

	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		pulse({3'b100, a, 4'h0});
		pulse({3'b001, a, 4'h0});
		d = rd_valid_i ? rd_data_i : 8'hxx;
	endtask

	task automatic ext_write(input logic [15:0] p, input logic [7:0] d);
		write_byte(REG_EXT_POINTER_LOW, p[7:0]);
		write_byte(REG_EXT_POINTER_HIGH, p[15:8]);
		write_byte(REG_EXT_DATA_PORT, d);
	endtask

	// Read, modify and write back, so untouched polarities survive.
	task automatic ext_merge(input logic [7:0] set_b, input logic [7:0] clr_b);
		logic [7:0] cur;
		read_byte(REG_PIN_POLARITY, cur);
		ext_write(EXT_PIN_POLARITY_ADDR, (cur | set_b) & ~clr_b);
	endtask
endmodule

`default_nettype wire

// File: flag_polarity_pkg.sv
// Shared constants, carriers and decoding for the flag select and polarity
// block. Assumes a single 20 MHz clock and an active-high synchronous reset.
`default_nettype none

package flag_polarity_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] REG_IFACE_CONFIG = 8'h01;
	localparam logic [7:0] REG_FLAG_SELECT_AB = 8'h02;
	localparam logic [7:0] REG_FLAG_SELECT_CD = 8'h03;
	localparam logic [7:0] REG_PIN_POLARITY = 8'h04;
	localparam logic [7:0] REG_EXT_POINTER_LOW = 8'h3A;
	localparam logic [7:0] REG_EXT_POINTER_HIGH = 8'h3B;
	localparam logic [7:0] REG_EXT_DATA_PORT = 8'h3C;
	localparam logic [15:0] EXT_PIN_POLARITY_ADDR = 16'hE609;

	localparam logic [7:0] IFACE_CONFIG_RESET = 8'hC9;
	localparam logic [7:0] FLAG_SELECT_RESET = 8'h00;
	localparam logic [7:0] PIN_POLARITY_RESET = 8'h00;
	localparam logic [15:0] EXT_POINTER_RESET = 16'h0000;

	localparam int POL_WAKE_BIT = 7;
	localparam int POL_COMMIT_BIT = 5;
	localparam int POL_OUT_ENABLE_BIT = 4;
	localparam int POL_READ_BIT = 3;
	localparam int POL_WRITE_BIT = 2;
	localparam int POL_EMPTY_BIT = 1;
	localparam int POL_FULL_BIT = 0;
	localparam int IFC_PIN_D_ROLE_BIT = 1;

	// Bits the command port may change directly, and through the pointer.
	localparam logic [7:0] POL_DIRECT_MASK = 8'hA3;
	localparam logic [7:0] POL_EXTENDED_MASK = 8'hBF;

	localparam logic [3:0] SEL_FIXED = 4'h0;
	localparam logic [1:0] KIND_PROG = 2'b01;
	localparam logic [1:0] KIND_EMPTY = 2'b10;
	localparam logic [1:0] KIND_FULL = 2'b11;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		FIXED_PROG = 2'b00,
		FIXED_FULL = 2'b01,
		FIXED_EMPTY = 2'b10,
		FIXED_NONE = 2'b11
	} fixed_kind_t;

	typedef enum logic {
		NIB_UPPER = 1'b0,
		NIB_LOWER = 1'b1
	} nibble_phase_t;

	typedef struct packed {
		logic addr_wr;
		logic data_wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] nibble;
	} cmd_t;

	typedef struct packed {
		logic [3:0] prog;
		logic [3:0] full;
		logic [3:0] empty;
	} fifo_status_t;

	typedef struct packed {
		logic wake;
		logic commit;
		logic out_enable;
		logic read;
		logic write;
	} strobe_t;

	////////////////////////////////////////////////////////////////////////
	function automatic fixed_kind_t pin_fixed_kind(input logic [1:0] pin);
		case (pin)
			2'd0: pin_fixed_kind = FIXED_PROG;
			2'd1: pin_fixed_kind = FIXED_FULL;
			2'd2: pin_fixed_kind = FIXED_EMPTY;
			default: pin_fixed_kind = FIXED_NONE;
		endcase
	endfunction

	// Input level seen through a polarity bit: 1 means the input is asserted.
	function automatic logic asserted_level(input logic raw, input logic pol);
		asserted_level = raw ~^ pol;
	endfunction

endpackage

`default_nettype wire

// File: flag_polarity_regs.sv
// Command-port register bank for flag pin routing and pin polarities.
// Assumes command strobes are one-cycle pulses synchronous to sys_clk_i.
`default_nettype none

module flag_polarity_regs
	import flag_polarity_pkg::*;
#(
	parameter int unsigned ENDPOINTS = 4
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire cmd_t cmd_i,
	input wire logic [2:0] fifo_select_pins_i,
	input wire fifo_status_t fifo_status_i,
	input wire strobe_t strobe_i,
	input wire logic pin_d_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic status_pin_a_o,
	output logic status_pin_b_o,
	output logic status_pin_c_o,
	output logic status_pin_d_o,
	output logic status_pin_d_oe_o,
	output logic chip_select_o,
	output strobe_t strobe_active_o
);

	if (ENDPOINTS != 4) begin : g_bad_endpoints
		$error("flag_polarity_regs serves exactly four endpoints");
	end

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] iface_config;
		logic [7:0] flag_select_ab;
		logic [7:0] flag_select_cd;
		logic [7:0] pin_polarity;
		logic [15:0] ext_pointer;
		logic [7:0] cmd_addr;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [3:0] pins;
		logic pin_d_oe;
		logic chip_select;
		strobe_t strobes;
	} cfg_state_t;

	localparam cfg_state_t RESET_STATE = '{
		iface_config: IFACE_CONFIG_RESET,
		flag_select_ab: FLAG_SELECT_RESET,
		flag_select_cd: FLAG_SELECT_RESET,
		pin_polarity: PIN_POLARITY_RESET,
		ext_pointer: EXT_POINTER_RESET,
		default: '0
	};

	cfg_state_t state;
	cfg_state_t next_state;

	logic byte_valid;
	logic [7:0] cmd_byte;
	logic [3:0][3:0] selectors;
	logic [3:0] pin_levels;
	logic [1:0] addressed_ep;
	logic pin_d_flag_role;

	////////////////////////////////////////////////////////////////////////
	// Command data nibbles are paired before any register sees them.

	nibble_assembler u_nibbles (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.clear_i(cmd_i.addr_wr),
		.nibble_valid_i(cmd_i.data_wr),
		.nibble_i(cmd_i.nibble),
		.byte_valid_o(byte_valid),
		.byte_o(cmd_byte)
	);

	////////////////////////////////////////////////////////////////////////
	// Flag routing: one selector per pin, decoded alike except fixed code 0, whose flag depends on the pin.

	assign selectors[0] = state.flag_select_ab[3:0];
	assign selectors[1] = state.flag_select_ab[7:4];
	assign selectors[2] = state.flag_select_cd[3:0];
	assign selectors[3] = state.flag_select_cd[7:4];
	assign addressed_ep = fifo_select_pins_i[1:0];
	assign pin_d_flag_role = state.iface_config[IFC_PIN_D_ROLE_BIT];

	for (genvar p = 0; p < 4; p++) begin : g_pins
		status_flag_mux u_mux (
			.select_i(selectors[p]),
			.fixed_i(pin_fixed_kind(2'(p))),
			.addressed_ep_i(addressed_ep),
			.status_i(fifo_status_i),
			.empty_pol_i(state.pin_polarity[POL_EMPTY_BIT]),
			.full_pol_i(state.pin_polarity[POL_FULL_BIT]),
			.level_o(pin_levels[p])
		);
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_state.rd_valid = 1'b0;

		if (cmd_i.addr_wr) begin
			next_state.cmd_addr = cmd_i.addr;
		end

		if (byte_valid) begin
			case (state.cmd_addr)
				REG_IFACE_CONFIG: next_state.iface_config = cmd_byte;
				REG_FLAG_SELECT_AB: next_state.flag_select_ab = cmd_byte;
				REG_FLAG_SELECT_CD: next_state.flag_select_cd = cmd_byte;
				REG_PIN_POLARITY: begin
					// The out-enable, read and write strobe polarity bits keep their value here.
					next_state.pin_polarity =
						(state.pin_polarity & ~POL_DIRECT_MASK) |
						(cmd_byte & POL_DIRECT_MASK);
				end
				REG_EXT_POINTER_LOW: next_state.ext_pointer[7:0] = cmd_byte;
				REG_EXT_POINTER_HIGH: next_state.ext_pointer[15:8] = cmd_byte;
				REG_EXT_DATA_PORT: begin
					// The extended copy shares storage with the direct one,
					// so a whole-byte write here replaces every writable bit;
					// the master is expected to merge first.
					if (state.ext_pointer == EXT_PIN_POLARITY_ADDR) begin
						next_state.pin_polarity =
							cmd_byte & POL_EXTENDED_MASK;
					end
				end
				default: next_state.pin_polarity = state.pin_polarity;
			endcase
		end

		if (cmd_i.rd) begin
			next_state.rd_valid = 1'b1;
			case (state.cmd_addr)
				REG_IFACE_CONFIG: next_state.rd_data = state.iface_config;
				REG_FLAG_SELECT_AB: next_state.rd_data = state.flag_select_ab;
				REG_FLAG_SELECT_CD: next_state.rd_data = state.flag_select_cd;
				REG_PIN_POLARITY: next_state.rd_data = state.pin_polarity;
				REG_EXT_POINTER_LOW: next_state.rd_data = state.ext_pointer[7:0];
				REG_EXT_POINTER_HIGH: next_state.rd_data = state.ext_pointer[15:8];
				REG_EXT_DATA_PORT: begin
					if (state.ext_pointer == EXT_PIN_POLARITY_ADDR) begin
						next_state.rd_data = state.pin_polarity;
					end else begin
						next_state.rd_data = 8'h00;
					end
				end
				default: next_state.rd_data = 8'h00;
			endcase
		end

		next_state.pins = pin_levels;
		next_state.pin_d_oe = pin_d_flag_role;
		// The shared pin is a low-active select only while it is an input.
		next_state.chip_select = !pin_d_flag_role && !pin_d_i;

		next_state.strobes.wake = asserted_level(strobe_i.wake,
			state.pin_polarity[POL_WAKE_BIT]);
		next_state.strobes.commit = asserted_level(strobe_i.commit,
			state.pin_polarity[POL_COMMIT_BIT]);
		next_state.strobes.out_enable = asserted_level(strobe_i.out_enable,
			state.pin_polarity[POL_OUT_ENABLE_BIT]);
		next_state.strobes.read = asserted_level(strobe_i.read,
			state.pin_polarity[POL_READ_BIT]);
		next_state.strobes.write = asserted_level(strobe_i.write,
			state.pin_polarity[POL_WRITE_BIT]);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= RESET_STATE;
		end else begin
			state <= next_state;
		end
	end

	assign rd_data_o = state.rd_data;
	assign rd_valid_o = state.rd_valid;
	assign status_pin_a_o = state.pins[0];
	assign status_pin_b_o = state.pins[1];
	assign status_pin_c_o = state.pins[2];
	assign status_pin_d_o = state.pins[3];
	assign status_pin_d_oe_o = state.pin_d_oe;
	assign chip_select_o = state.chip_select;
	assign strobe_active_o = state.strobes;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	select_store_a: assert property (
		byte_valid && state.cmd_addr == REG_FLAG_SELECT_CD
		|=> state.flag_select_cd == $past(cmd_byte))
		else $error("pin C/D selector not stored");

	fixed_full_a: assert property (
		state.flag_select_ab[7:4] == SEL_FIXED &&
		fifo_status_i.full[fifo_select_pins_i[1:0]]
		|=> status_pin_b_o == $past(state.pin_polarity[POL_FULL_BIT]))
		else $error("pin B does not show addressed full flag");

	routed_empty_a: assert property (
		state.flag_select_ab[3:2] == KIND_EMPTY
		|=> status_pin_a_o == !($past(fifo_status_i.empty[
			state.flag_select_ab[1:0]]) ^
			$past(state.pin_polarity[POL_EMPTY_BIT])))
		else $error("pin A does not follow routed empty flag");

	reserved_park_a: assert property (
		state.flag_select_cd[3:0] inside {4'h1, 4'h2, 4'h3}
		|=> status_pin_c_o == !$past(state.pin_polarity[POL_FULL_BIT]))
		else $error("reserved code does not park pin C");

	wake_level_a: assert property (
		1'b1 |=> strobe_active_o.wake ==
			($past(strobe_i.wake) ~^ $past(state.pin_polarity[POL_WAKE_BIT])))
		else $error("wake input polarity not applied");

	commit_level_a: assert property (
		!state.pin_polarity[POL_COMMIT_BIT] && !strobe_i.commit
		|=> strobe_active_o.commit)
		else $error("low packet commit not seen as asserted");

	full_route_a: assert property (
		state.flag_select_cd[3:0] == {KIND_FULL, 2'b00} &&
		fifo_status_i.full[0] && state.pin_polarity[POL_FULL_BIT]
		|=> status_pin_c_o)
		else $error("high full polarity not shown on pin C");

	strobe_pol_locked_a: assert property (
		byte_valid && state.cmd_addr == REG_PIN_POLARITY
		|=> state.pin_polarity[4:2] == $past(state.pin_polarity[4:2]))
		else $error("direct write changed strobe polarity bits");

	extended_write_a: assert property (
		byte_valid && state.cmd_addr == REG_EXT_DATA_PORT &&
		state.ext_pointer == EXT_PIN_POLARITY_ADDR
		|=> state.pin_polarity == ($past(cmd_byte) & POL_EXTENDED_MASK))
		else $error("extended polarity write not applied");

	pointer_low_a: assert property (
		byte_valid && state.cmd_addr == REG_EXT_POINTER_LOW
		|=> state.ext_pointer[7:0] == $past(cmd_byte))
		else $error("pointer low byte not loaded");

	pointer_high_a: assert property (
		byte_valid && state.cmd_addr == REG_EXT_POINTER_HIGH
		|=> state.ext_pointer[15:8] == $past(cmd_byte) ##1
			state.ext_pointer[15:8] == $past(state.ext_pointer[15:8], 1) ||
			byte_valid)
		else $error("pointer high byte not loaded");

	pointer_miss_a: assert property (
		byte_valid && state.cmd_addr == REG_EXT_DATA_PORT &&
		state.ext_pointer != EXT_PIN_POLARITY_ADDR
		|=> $stable(state.pin_polarity))
		else $error("data port wrote with pointer elsewhere");

	pin_d_role_a: assert property (
		!pin_d_flag_role |=> !status_pin_d_oe_o ##1
			(status_pin_d_oe_o == $past(pin_d_flag_role)))
		else $error("pin D driven while it is a chip select");

	// Flag pins lag their selector and status inputs by one cycle.
	fixed_prog_a: assert property (
		state.flag_select_ab[3:0] == SEL_FIXED
		|=> status_pin_a_o ==
			$past(fifo_status_i.prog[fifo_select_pins_i[1:0]]))
		else $error("pin A does not show addressed level flag");

	fixed_empty_a: assert property (
		state.flag_select_cd[3:0] == SEL_FIXED
		|=> status_pin_c_o ==
			!($past(fifo_status_i.empty[fifo_select_pins_i[1:0]]) ^
			$past(state.pin_polarity[POL_EMPTY_BIT])))
		else $error("pin C does not show addressed empty flag");

	routed_prog_a: assert property (
		state.flag_select_ab[7:6] == KIND_PROG
		|=> status_pin_b_o ==
			$past(fifo_status_i.prog[state.flag_select_ab[5:4]]))
		else $error("pin B does not follow routed level flag");

	reserved_pin_a: assert property (
		state.flag_select_ab[3:0] inside {4'h1, 4'h2, 4'h3}
		|=> status_pin_a_o == !$past(state.pin_polarity[POL_FULL_BIT]))
		else $error("reserved code does not park pin A");

	empty_low_a: assert property (
		state.flag_select_cd[7:4] == {KIND_EMPTY, 2'b01} &&
		fifo_status_i.empty[1] && !state.pin_polarity[POL_EMPTY_BIT]
		|=> !status_pin_d_o)
		else $error("low empty polarity not shown on pin D");

	strobe_ext_level_a: assert property (
		1'b1 |=> strobe_active_o.out_enable ==
			($past(strobe_i.out_enable) ~^
			$past(state.pin_polarity[POL_OUT_ENABLE_BIT])) &&
			strobe_active_o.read == ($past(strobe_i.read) ~^
			$past(state.pin_polarity[POL_READ_BIT])) &&
			strobe_active_o.write == ($past(strobe_i.write) ~^
			$past(state.pin_polarity[POL_WRITE_BIT])))
		else $error("strobe pin polarity not applied");

	chip_select_a: assert property (
		1'b1 |=> chip_select_o ==
			!($past(pin_d_flag_role) || $past(pin_d_i)))
		else $error("chip select does not follow pin D");

	first_nibble_a: assert property (
		cmd_i.addr_wr ##1 !cmd_i.data_wr ##1
		(cmd_i.data_wr && !cmd_i.addr_wr) |-> !byte_valid)
		else $error("first nibble after address completed a byte");

endmodule

`default_nettype wire

// File: nibble_assembler.sv
// Joins two command data nibbles into one byte, upper nibble first.
// Assumes a command address write restarts the pairing.
`default_nettype none

module nibble_assembler
	import flag_polarity_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic nibble_valid_i,
	input wire logic [3:0] nibble_i,
	output logic byte_valid_o,
	output logic [7:0] byte_o
);

	typedef struct packed {
		nibble_phase_t phase;
		logic [3:0] upper;
	} nib_state_t;

	nib_state_t state;
	nib_state_t next_state;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		if (clear_i) begin
			next_state.phase = NIB_UPPER;
		end else if (nibble_valid_i) begin
			case (state.phase)
				NIB_UPPER: begin
					next_state.upper = nibble_i;
					next_state.phase = NIB_LOWER;
				end
				NIB_LOWER: next_state.phase = NIB_UPPER;
				default: next_state.phase = NIB_UPPER;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= '{phase: NIB_UPPER, upper: 4'h0};
		end else begin
			state <= next_state;
		end
	end

	// The byte is only complete on the second nibble of a pair.
	assign byte_valid_o = nibble_valid_i && !clear_i &&
		(state.phase == NIB_LOWER);
	assign byte_o = {state.upper, nibble_i};

	upper_first_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(nibble_valid_i && !clear_i && state.phase == NIB_UPPER)
		##1 (nibble_valid_i && !clear_i)
		|-> byte_valid_o && byte_o == {$past(nibble_i), nibble_i})
		else $error("byte not built upper nibble first");

endmodule

`default_nettype wire

// File: status_flag_mux.sv
// Chooses the level of one flag output pin from the endpoint FIFO status.
// Assumes the status inputs are active high and already synchronous.
`default_nettype none

module status_flag_mux
	import flag_polarity_pkg::*;
(
	input wire logic [3:0] select_i,
	input wire fixed_kind_t fixed_i,
	input wire logic [1:0] addressed_ep_i,
	input wire fifo_status_t status_i,
	input wire logic empty_pol_i,
	input wire logic full_pol_i,
	output logic level_o
);

	logic [1:0] ep;

	always_comb begin
		ep = select_i[1:0];
		// A reserved code parks the pin at the level of a full flag that is
		// not full, so a stray code never looks like a live flag.
		level_o = !full_pol_i;
		if (select_i == SEL_FIXED) begin
			case (fixed_i)
				FIXED_PROG: level_o = status_i.prog[addressed_ep_i];
				FIXED_FULL:
					level_o = !(status_i.full[addressed_ep_i] ^ full_pol_i);
				FIXED_EMPTY:
					level_o = !(status_i.empty[addressed_ep_i] ^ empty_pol_i);
				default: level_o = !full_pol_i;
			endcase
		end else begin
			case (select_i[3:2])
				KIND_PROG: level_o = status_i.prog[ep];
				KIND_EMPTY: level_o = !(status_i.empty[ep] ^ empty_pol_i);
				KIND_FULL: level_o = !(status_i.full[ep] ^ full_pol_i);
				default: level_o = !full_pol_i;
			endcase
		end
	end

endmodule

`default_nettype wire
